// ---- cab_decode_unit.sv ----
// Decode and execute unit for base-relative, PC-relative and branch instructions.
// Function
// (RULE1) Stores of reg zero at base plus scaled displacement.
// (RULE2) Byte and word base loads sign-extend.
// (RULE3) Longword base load copies word unchanged.
// (RULE4) Indexed byte logic ops read, combine, write back.
// (RULE5) Indexed byte test sets flag when zero.
// (RULE6) PC word load sign-extends into register.
// (RULE7) PC longword load uses aligned PC base.
// (RULE8) Address generate writes aligned address to zero.
// (RULE9) Register far branch jumps to register plus PC.
// (RULE10) Register subroutine branch saves return, delayed.
// (RULE11) Branch if false jumps when flag clear.
// (RULE12) Branch if true jumps when flag set.
// (RULE13) Delayed branch if false, slot first.
// (RULE14) Delayed branch if true, slot first.
// (RULE15) Relative branch delayed, 12-bit displacement.
// (RULE16) Relative subroutine branch saves return, delayed.
// (RULE17) Float zero load writes all zeros.
// (RULE18) Float one load writes one encoding.
// (RULE19) Move displacements unsigned, branch displacements signed.
// (RULE20) Delay slot executes before the transfer.
// (RULE21) Only byte test alters flag; no privilege.
`timescale 1ns/1ps
`include "cab_defs.svh"

module cab_decode_unit
  import cab_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  // Load/store unit
  output cab_mem_req_s      memOut,
  input  wire logic         memAck,
  input  wire logic [31:0]  memRdata
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  cab_state_s  s;
  cab_state_s  next_s;
  logic [15:0] ir;
  logic [3:0]  rn;
  logic [31:0] pc4;
  logic [31:0] pcAl;
  logic [31:0] zd;
  logic [31:0] brd8;
  logic [31:0] brd12;
  logic [7:0]  rmw;
  logic        retire;
  logic        jump;
  logic        dly;
  logic [31:0] tgt;
  logic        busy;
  logic [31:0] rdVal;

  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign prdata  = s.prdata;
  assign memOut  = s.mem;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    ir     = s.ir;
    rn     = s.ir[11:8];
    pc4    = s.pc + 32'h0000_0004;
    pcAl   = {s.pc[31:2], 2'b00} + 32'h0000_0004;
    zd     = {24'h00_0000, s.ir[7:0]};                             // RULE19
    brd8   = sext8(s.ir[7:0]) << 1;                                // RULE19
    brd12  = {{20{s.ir[11]}}, s.ir[11:0]} << 1;                    // RULE19
    rmw    = 8'h00;
    retire = 1'b0;
    jump   = 1'b0;
    dly    = 1'b0;
    tgt    = 32'h0000_0000;
    busy   = (s.st != CAB_IDLE);
    rdVal  = 32'h0000_0000;

    unique case (s.st)
      CAB_IDLE:
      begin
      end
      CAB_EXEC:
      begin
        retire = 1'b1;
        if (ir[15:12] == `CAB_NIB_PCLDW)
        begin
          next_s.mem = '{1'b1, 1'b0, CAB_SZ_WORD, pc4 + (zd << 1), 32'h0000_0000}; // RULE6
          retire = 1'b0;
        end
        else if (ir[15:12] == `CAB_NIB_PCLDL)
        begin
          next_s.mem = '{1'b1, 1'b0, CAB_SZ_LONG, pcAl + (zd << 2), 32'h0000_0000}; // RULE7
          retire = 1'b0;
        end
        else if (ir[15:12] == `CAB_NIB_REL)
        begin
          tgt = pc4 + brd12;                                        // RULE15
          dly = 1'b1;
        end
        else if (ir[15:12] == `CAB_NIB_RELSUB)
        begin
          next_s.procReturn = pc4;                                  // RULE16
          tgt = pc4 + brd12;
          dly = 1'b1;
        end
        else if (ir[15:12] == `CAB_NIB_ZERO && ir[7:0] == `CAB_LO_RFAR)
        begin
          tgt  = s.gpr[rn] + pc4;                                   // RULE9
          jump = 1'b1;
        end
        else if (ir[15:12] == `CAB_NIB_ZERO && ir[7:0] == `CAB_LO_RSUB)
        begin
          next_s.procReturn = pc4;                                  // RULE10
          tgt = s.gpr[rn] + pc4;
          dly = 1'b1;
        end
        else if (ir[15:12] == `CAB_NIB_FLOAT && ir[7:0] == `CAB_LO_FZERO)
        begin
          next_s.fpr[rn] = `CAB_FP_ZERO;                            // RULE17
        end
        else if (ir[15:12] == `CAB_NIB_FLOAT && ir[7:0] == `CAB_LO_FONE)
        begin
          next_s.fpr[rn] = `CAB_FP_ONE;                             // RULE18
        end
        else if (ir[15:8] == `CAB_OP_STB || ir[15:8] == `CAB_OP_STW
                 || ir[15:8] == `CAB_OP_STL)
        begin
          next_s.mem = '{1'b1, 1'b1, cab_size_e'(ir[9:8]),
                         s.globalBase + (zd << ir[9:8]), s.gpr[0]};  // RULE1
          next_s.st  = CAB_WRITE;
          retire = 1'b0;
        end
        else if (ir[15:8] == `CAB_OP_LDB || ir[15:8] == `CAB_OP_LDW
                 || ir[15:8] == `CAB_OP_LDL)
        begin
          next_s.mem = '{1'b1, 1'b0, cab_size_e'(ir[9:8]),
                         s.globalBase + (zd << ir[9:8]), 32'h0000_0000}; // RULE2 RULE3
          retire = 1'b0;
        end
        else if (ir[15:8] == `CAB_OP_ADRGEN)
        begin
          next_s.gpr[0] = pcAl + (zd << 2);                         // RULE8
        end
        else if (ir[15:10] == 6'b110011)
        begin
          next_s.mem = '{1'b1, 1'b0, CAB_SZ_BYTE,
                         s.gpr[0] + s.globalBase, 32'h0000_0000};    // RULE4 RULE5
          retire = 1'b0;
        end
        else if (ir[15:8] == `CAB_OP_BRT || ir[15:8] == `CAB_OP_BRF
                 || ir[15:8] == `CAB_OP_BRTD || ir[15:8] == `CAB_OP_BRFD)
        begin
          // Bit 9 picks the sense, bit 10 the delayed form.
          tgt  = pc4 + brd8;
          jump = (s.t == ~ir[9]) && !ir[10];                        // RULE11 RULE12
          dly  = (s.t == ~ir[9]) && ir[10];                         // RULE13 RULE14
        end
        else
        begin
          next_s.illegal = 1'b1;
        end
        if (!retire && next_s.st == CAB_EXEC)
        begin
          next_s.st = CAB_READ;
        end
      end
      CAB_READ:
      begin
        if (memAck)
        begin
          next_s.mem.req = 1'b0;
          retire = 1'b1;
          unique case (s.mem.size)
            CAB_SZ_BYTE: rdVal = sext8(memRdata[7:0]);              // RULE2
            CAB_SZ_WORD: rdVal = sext16(memRdata[15:0]);            // RULE2 RULE6
            default:     rdVal = memRdata;                          // RULE3 RULE7
          endcase
          if (ir[15:8] == `CAB_OP_BTEST)
          begin
            next_s.t = ((memRdata[7:0] & ir[7:0]) == 8'h00);        // RULE5 RULE21
          end
          else if (ir[15:10] == 6'b110011)
          begin
            unique case (ir[9:8])
              2'b01:   rmw = memRdata[7:0] & ir[7:0];
              2'b10:   rmw = memRdata[7:0] ^ ir[7:0];
              default: rmw = memRdata[7:0] | ir[7:0];
            endcase
            // The write goes back to the address just read.
            next_s.mem.req   = 1'b1;                                // RULE4
            next_s.mem.we    = 1'b1;
            next_s.mem.wdata = {24'h00_0000, rmw};
            next_s.st        = CAB_WRITE;
            retire = 1'b0;
          end
          else if (ir[15:12] == `CAB_NIB_PCLDW || ir[15:12] == `CAB_NIB_PCLDL)
          begin
            next_s.gpr[rn] = rdVal;                                 // RULE6 RULE7
          end
          else
          begin
            next_s.gpr[0] = rdVal;                                  // RULE2 RULE3
          end
        end
      end
      CAB_WRITE:
      begin
        if (memAck)
        begin
          next_s.mem.req = 1'b0;
          next_s.mem.we  = 1'b0;
          retire = 1'b1;
        end
      end
    endcase

    // Retirement: a pending delayed target is taken only after the slot
    // instruction has run, so the slot sees the sequential PC.
    if (retire)
    begin
      next_s.st = CAB_IDLE;
      if (jump)
      begin
        next_s.pc = tgt;
      end
      else if (s.slot)
      begin
        next_s.pc   = s.slotTgt;                                    // RULE20
        next_s.slot = 1'b0;
      end
      else
      begin
        next_s.pc = s.pc + 32'h0000_0002;
      end
      if (dly)
      begin
        next_s.slot    = 1'b1;                                      // RULE20
        next_s.slotTgt = tgt;
      end
    end

    // APB: one wait cycle, then pready; writes commit on the pready edge.
    // No privilege check exists anywhere on this path.
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr)
        `CAB_OFF_INSTR: next_s.prdata = {16'h0000, s.ir};
        `CAB_OFF_PC:    next_s.prdata = s.pc;
        `CAB_OFF_GBASE: next_s.prdata = s.globalBase;
        `CAB_OFF_PRET:  next_s.prdata = s.procReturn;
        `CAB_OFF_SEL:   next_s.prdata = {28'h000_0000, s.sel};
        `CAB_OFF_GPR:   next_s.prdata = s.gpr[s.sel];
        `CAB_OFF_FPR:   next_s.prdata = s.fpr[s.sel];
        `CAB_OFF_STAT:
        begin
          next_s.prdata[`CAB_STAT_BUSY] = busy;
          next_s.prdata[`CAB_STAT_T]    = s.t;
          next_s.prdata[`CAB_STAT_SLOT] = s.slot;
          next_s.prdata[`CAB_STAT_ILL]  = s.illegal;
        end
        default:        next_s.pslverr = 1'b1;
      endcase
      // Writes while an instruction is in flight would race it, so refuse.
      if (pwrite && busy)
      begin
        next_s.pslverr = 1'b1;
      end
    end
    else if (psel && penable && pwrite && !s.pslverr)
    begin
      unique case (paddr)
        `CAB_OFF_INSTR:
        begin
          next_s.ir      = pwdata[15:0];
          next_s.illegal = 1'b0;
          next_s.st      = CAB_EXEC;
        end
        `CAB_OFF_PC:    next_s.pc         = pwdata;
        `CAB_OFF_GBASE: next_s.globalBase = pwdata;
        `CAB_OFF_PRET:  next_s.procReturn = pwdata;
        `CAB_OFF_SEL:   next_s.sel        = pwdata[3:0];
        `CAB_OFF_GPR:   next_s.gpr[s.sel] = pwdata;
        `CAB_OFF_FPR:   next_s.fpr[s.sel] = pwdata;
        `CAB_OFF_STAT:
        begin
          next_s.t    = pwdata[`CAB_STAT_T];
          next_s.slot = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s    <= '0;
      s.st <= CAB_IDLE;
      s.pc <= `CAB_PC_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule // cab_decode_unit

// ---- cab_defs.svh ----
// Register offsets, field positions, reset values and opcodes of the decode unit.
`ifndef CAB_DEFS_SVH
`define CAB_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CAB_OFF_INSTR  8'h00
`define CAB_OFF_PC     8'h04
`define CAB_OFF_GBASE  8'h08
`define CAB_OFF_PRET   8'h0C
`define CAB_OFF_SEL    8'h10
`define CAB_OFF_GPR    8'h14
`define CAB_OFF_FPR    8'h18
`define CAB_OFF_STAT   8'h1C

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define CAB_STAT_BUSY  0
`define CAB_STAT_T     1
`define CAB_STAT_SLOT  2
`define CAB_STAT_ILL   3

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define CAB_PC_RST     32'h0000_0000
`define CAB_FP_ZERO    32'h0000_0000
`define CAB_FP_ONE     32'h3F80_0000

// ----------------------------------------------------------------------
// Opcodes, upper byte or nibble, and lower-byte function codes
// ----------------------------------------------------------------------
`define CAB_OP_STB     8'hC0
`define CAB_OP_STW     8'hC1
`define CAB_OP_STL     8'hC2
`define CAB_OP_LDB     8'hC4
`define CAB_OP_LDW     8'hC5
`define CAB_OP_LDL     8'hC6
`define CAB_OP_ADRGEN  8'hC7
`define CAB_OP_BTEST   8'hCC
`define CAB_OP_BAND    8'hCD
`define CAB_OP_BXOR    8'hCE
`define CAB_OP_BOR     8'hCF
`define CAB_OP_BRT     8'h89
`define CAB_OP_BRF     8'h8B
`define CAB_OP_BRTD    8'h8D
`define CAB_OP_BRFD    8'h8F
`define CAB_NIB_PCLDW  4'h9
`define CAB_NIB_PCLDL  4'hD
`define CAB_NIB_REL    4'hA
`define CAB_NIB_RELSUB 4'hB
`define CAB_NIB_ZERO   4'h0
`define CAB_NIB_FLOAT  4'hF
`define CAB_LO_RFAR    8'h23
`define CAB_LO_RSUB    8'h03
`define CAB_LO_FZERO   8'h8D
`define CAB_LO_FONE    8'h9D

`endif

// ---- cab_pkg.sv ----
// Types shared by the decode unit and its bench.
package cab_pkg;

  typedef enum logic [3:0] {
    CAB_IDLE  = 4'b0001,
    CAB_EXEC  = 4'b0010,
    CAB_READ  = 4'b0100,
    CAB_WRITE = 4'b1000
  } cab_state_e;

  typedef enum logic [1:0] {
    CAB_SZ_BYTE = 2'b00,
    CAB_SZ_WORD = 2'b01,
    CAB_SZ_LONG = 2'b10
  } cab_size_e;

  typedef struct packed {
    logic        req;
    logic        we;
    cab_size_e   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cab_mem_req_s;

  typedef struct packed {
    cab_state_e        st;
    logic [15:0]       ir;
    logic [31:0]       pc;
    logic [31:0]       globalBase;
    logic [31:0]       procReturn;
    logic [3:0]        sel;
    logic              t;
    logic              slot;
    logic [31:0]       slotTgt;
    logic              illegal;
    logic [15:0][31:0] gpr;
    logic [15:0][31:0] fpr;
    cab_mem_req_s      mem;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } cab_state_s;

endpackage

// ---- cab_decode_unit_asserts.sv ----
// Port-level checker for the decode unit.
`timescale 1ns/1ps
`include "cab_defs.svh"
module cab_decode_unit_asserts
  import cab_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // APB slave
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Load/store unit
  input wire cab_mem_req_s memOut,
  input wire logic         memAck
);
  logic [15:0] lastOp;
  logic [31:0] rdAddr;
  logic [7:0]  opHi;

  // ----------------------------------------------------------------------
  // Track the committed opcode
  // ----------------------------------------------------------------------
  // Refused writes leave the opcode alone, so they must not move the tracker.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lastOp <= 16'h0000;
      rdAddr <= 32'h0000_0000;
    end
    else
    begin
      if (pready && !pslverr && pwrite && paddr == `CAB_OFF_INSTR)
        lastOp <= pwdata[15:0];
      if (memOut.req && memAck)
        rdAddr <= memOut.addr;
    end
  end
  assign opHi = lastOp[15:8];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_logic_read;
    memOut.req && !memOut.we && memAck && opHi inside {8'hCD, 8'hCE, 8'hCF};
  endsequence
  sequence s_write_back;
    memOut.req && memOut.we && memOut.addr == rdAddr && memOut.size == CAB_SZ_BYTE;
  endsequence

  a_store_size: assert property (
    memOut.req && opHi inside {`CAB_OP_STB, `CAB_OP_STW, `CAB_OP_STL}
    |-> memOut.we && memOut.size == cab_size_e'(opHi[1:0])) else $error("store kind wrong");
  a_load_size: assert property (
    memOut.req && opHi inside {`CAB_OP_LDB, `CAB_OP_LDW, `CAB_OP_LDL}
    |-> !memOut.we && memOut.size == cab_size_e'(opHi[1:0])) else $error("load kind wrong");
  a_logic_order: assert property (
    s_logic_read |-> ##[1:3] s_write_back) else $error("no write back");
  a_test_nowrite: assert property (
    memOut.req && opHi == `CAB_OP_BTEST |-> !memOut.we && memOut.size == CAB_SZ_BYTE)
    else $error("test wrote memory");
  a_pc_word: assert property (
    memOut.req && lastOp[15:12] == `CAB_NIB_PCLDW
    |-> !memOut.we && memOut.size == CAB_SZ_WORD && !memOut.addr[0]) else $error("pc word");
  a_pc_long: assert property (
    memOut.req && lastOp[15:12] == `CAB_NIB_PCLDL
    |-> !memOut.we && memOut.size == CAB_SZ_LONG && memOut.addr[1:0] == 2'b00)
    else $error("pc long");
  a_no_access: assert property (
    opHi inside {`CAB_OP_ADRGEN, `CAB_OP_BRT, `CAB_OP_BRF, `CAB_OP_BRTD, `CAB_OP_BRFD}
    || lastOp[15:12] inside {4'h0, 4'hA, 4'hB, 4'hF} |-> !memOut.req) else $error("stray access");
  a_req_hold: assert property (
    memOut.req && !memAck |=> memOut.req && $stable(memOut.addr) && $stable(memOut.we))
    else $error("request dropped");
endmodule // cab_decode_unit_asserts

bind cab_decode_unit cab_decode_unit_asserts i_cab_decode_unit_asserts (.clk, .rst_b, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .memOut, .memAck);

// ---- cab_mem_model.sv ----
// Behavioural load/store unit with byte memory and random wait states.
`timescale 1ns/1ps
module cab_mem_model
  import cab_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Request side
  input  wire cab_mem_req_s memOut,
  output logic              memAck,
  output logic [31:0]       memRdata
);
  bit [7:0] mem [bit [31:0]];
  int       waitN;

  // ----------------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------------
  // Idle read data toggles so that a stale value is never mistaken for a fresh one.
  initial memRdata = 32'h5a5a_a5a5;
  always @(posedge clk)
  begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    if (!rst_b)
      waitN <= 0;
    else if (memOut.req && !memAck && waitN > 0)
      waitN <= waitN - 1;
    else if (memOut.req && !memAck)
    begin
      memRdata <= $urandom;
      for (int i = 0; i < (1 << memOut.size); i++)
        if (memOut.we)
          mem[memOut.addr + i] = memOut.wdata[8*i +: 8];
        else
          memRdata[8*i +: 8] <= mem[memOut.addr + i];
      memAck <= 1'b1;
      waitN  <= $urandom_range(3);
    end
  end
endmodule // cab_mem_model

// ---- cab_decode_unit_tb.sv ----
// Self-checking bench for the decode unit.
`timescale 1ns/1ps
`include "cab_defs.svh"
module cab_decode_unit_tb;
  import cab_pkg::*;
  logic         clk;
  logic         rst_b;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  cab_mem_req_s memOut;
  logic         memAck;
  logic [31:0]  memRdata;
  logic [31:0]  r;
  logic         e;
  logic [31:0]  gb, pc, v, a, x, tgt;
  logic [11:0]  w;
  logic [7:0]   b, im;
  logic         t, tk, dl;
  int           k, j, n;
  int           bad_count;
  int           samples_checked;

  cab_decode_unit i_cab_decode_unit (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .memOut, .memAck, .memRdata);
  cab_mem_model i_cab_mem_model (.clk, .rst_b, .memOut, .memAck, .memRdata);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int c;
    c = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (pready !== 1'b1 && c < 9);
    r = prdata;
    e = pslverr;
    if (c >= 9)
    begin
      bad_count++;
      give_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic peek(input int idx, input logic [7:0] off);
    apb(1'b1, `CAB_OFF_SEL, idx);
    apb(1'b0, off, 32'h0000_0000);
  endtask

  task automatic gpr(input int idx, input logic [31:0] d);
    apb(1'b1, `CAB_OFF_SEL, idx);
    apb(1'b1, `CAB_OFF_GPR, d);
  endtask

  // Software must see busy clear before it issues the next opcode.
  task automatic run(input logic [15:0] op);
    int c;
    c = 0;
    apb(1'b1, `CAB_OFF_INSTR, {16'h0000, op});
    do
    begin
      apb(1'b0, `CAB_OFF_STAT, 32'h0000_0000);
      c++;
    end
    while (r[`CAB_STAT_BUSY] !== 1'b0 && c < 40);
    if (c >= 40)
    begin
      bad_count++;
      give_verdict();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'h1ff5));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, `CAB_OFF_PC, 32'h0000_0000);
    chk(`CAB_PC_RST, r);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'h0000_0001, e);
    gb = $urandom & 32'h00FF_FFFC;
    apb(1'b1, `CAB_OFF_GBASE, gb);
    for (k = 0; k < 3; k++)
    begin
      b = $urandom;
      v = $urandom | 32'h0000_8080;
      a = gb + b * (1 << k);
      gpr(0, v);
      run({`CAB_OP_STB + k[7:0], b});
      for (j = 0; j < (1 << k); j++)
        chk(v[8*j +: 8], i_cab_mem_model.mem[a + j]);
      run({`CAB_OP_LDB + k[7:0], b});
      peek(0, `CAB_OFF_GPR);
      chk(k == 0 ? {{24{v[7]}}, v[7:0]} : k == 1 ? {{16{v[15]}}, v[15:0]} : v, r);
    end
    for (j = 0; j < 5; j++)
    begin
      x = $urandom_range(255);
      b = $urandom;
      im = (j == 4) ? ~b : 8'($urandom);
      t = $urandom;
      i_cab_mem_model.mem[gb + x] = b;
      gpr(0, x);
      apb(1'b1, `CAB_OFF_STAT, {30'h0, t, 1'b0});
      run({j == 0 ? `CAB_OP_BAND : j == 1 ? `CAB_OP_BOR : j == 2 ? `CAB_OP_BXOR : `CAB_OP_BTEST, im});
      chk(j == 0 ? b & im : j == 1 ? b | im : j == 2 ? b ^ im : b, i_cab_mem_model.mem[gb + x]);
      apb(1'b0, `CAB_OFF_STAT, 32'h0000_0000);
      chk(j < 3 ? t : (b & im) == 8'h00, r[`CAB_STAT_T]);
    end
    for (k = 0; k < 3; k++)
    begin
      pc = $urandom & 32'h000F_FFFE;
      b = $urandom;
      n = (k == 2) ? 0 : $urandom_range(15, 1);
      v = $urandom | 32'h0000_8000;
      a = (k == 0) ? pc + 4 + 2 * b : (pc & 32'hFFFF_FFFC) + 4 + 4 * b;
      for (j = 0; j < 4; j++)
        i_cab_mem_model.mem[a + j] = v[8*j +: 8];
      apb(1'b1, `CAB_OFF_PC, pc);
      run({k == 0 ? `CAB_NIB_PCLDW : k == 1 ? `CAB_NIB_PCLDL : 4'hC, k == 2 ? 4'h7 : n[3:0], b});
      peek(n, `CAB_OFF_GPR);
      chk(k == 0 ? {{16{v[15]}}, v[15:0]} : k == 1 ? v : a, r);
    end
    for (k = 0; k < 2; k++)
    begin
      run({8'hF0, k == 0 ? `CAB_LO_FONE : `CAB_LO_FZERO});
      peek(0, `CAB_OFF_FPR);
      chk(k == 0 ? `CAB_FP_ONE : `CAB_FP_ZERO, r);
    end
    run(16'hC300);
    apb(1'b0, `CAB_OFF_STAT, 32'h0000_0000);
    chk(32'h0000_0001, r[`CAB_STAT_ILL]);
    for (j = 0; j < 16; j++)
    begin
      k = j % 8;
      t = j / 8;
      pc = $urandom & 32'h000F_FFFE;
      v = $urandom & 32'h000F_FFFE;
      n = $urandom_range(15, 1);
      w = $urandom;
      if (k < 4)
        w = {{4{w[7]}}, w[7:0]};
      tgt = (k >= 6) ? pc + 4 + v : pc + 4 + {{19{w[11]}}, w, 1'b0};
      tk = (k < 4) ? t ^ k[0] : 1'b1;
      dl = (k >= 2 && k != 6);
      gpr(n, v);
      apb(1'b1, `CAB_OFF_STAT, {30'h0, t, 1'b0});
      apb(1'b1, `CAB_OFF_PC, pc);
      run(k < 4 ? {`CAB_OP_BRT + 8'(2 * k), w[7:0]} : k < 6 ? {4'hA + 4'(k - 4), w}
          : {4'h0, n[3:0], k == 6 ? `CAB_LO_RFAR : `CAB_LO_RSUB});
      apb(1'b0, `CAB_OFF_PC, 32'h0000_0000);
      chk(dl || !tk ? pc + 2 : tgt, r);
      if (dl)
      begin
        run({4'hF, 4'(k + 1), t ? `CAB_LO_FZERO : `CAB_LO_FONE});
        apb(1'b0, `CAB_OFF_PC, 32'h0000_0000);
        chk(tk ? tgt : pc + 4, r);
        peek(k + 1, `CAB_OFF_FPR);
        chk(t ? `CAB_FP_ZERO : `CAB_FP_ONE, r);
      end
      if (k == 5 || k == 7)
      begin
        apb(1'b0, `CAB_OFF_PRET, 32'h0000_0000);
        chk(pc + 4, r);
      end
      apb(1'b0, `CAB_OFF_STAT, 32'h0000_0000);
      chk(t, r[`CAB_STAT_T]);
    end
    give_verdict();
  end
endmodule // cab_decode_unit_tb
